// [rtl/sync2.sv]
// Purpose: two-flop synchroniser for one level from outside the clock domain
// Assumes: async active-low reset already released cleanly
// Notes:   first stage is read only by the second
`timescale 1ns/1ns
module sync2 (
  input  wire logic clk_i,   // core clock
  input  wire logic rst_n_i, // active-low reset
  input  wire logic d_i,     // async level
  output logic      q_o      // synchronised level
);
  logic meta_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= 1'b0;
      q_o      <= 1'b0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule // sync2

// [rtl/usb_last_transfer_status.sv]
// Purpose: last-transfer status and device-mode control registers of a usb engine
// Assumes: transaction-done strobe and token strobes come from the engine on core_clk_i;
//          single-ended-zero level comes from the bus receiver pins
// Notes:   read data valid one cycle after the read strobe
//
// Overview of operation
// - the status register shows in bits 7..4 the endpoint number 0..15 of the last transfer.
// - the direction bit 3 reads 1 after a transmit and 0 after a receive.
// - the bank bit 2 reads 1 after an odd-bank transfer and 0 after an even-bank one.
// - status bits 15..8 and 1..0 read zero and ignore writes.
// - the status fields are read-only, set by hardware only, and reset to zero.
// - the control register live flag follows a single-ended zero on the bus lines.
// - a received SETUP token sets the packet processing halt bit until software clears it.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module usb_last_transfer_status
  import usb_stat_pkg::*;
(
  input  wire logic                            core_clk_i,      // 50 MHz clock
  input  wire logic                            resetn_i,        // async active-low reset
  input  wire logic [usb_stat_pkg::ADDR_W-1:0] addr_i,          // register index
  input  wire logic [usb_stat_pkg::DATA_W-1:0] wdata_i,         // write data
  input  wire logic                            wr_i,            // write strobe
  input  wire logic                            rd_i,            // read strobe
  output logic      [usb_stat_pkg::DATA_W-1:0] rdata_o,         // read data, cycle after rd_i
  input  wire logic                            xact_done_i,     // transaction complete pulse
  input  wire logic [usb_stat_pkg::EP_W-1:0]   xact_ep_i,       // endpoint of that transaction
  input  wire logic                            xact_tx_i,       // 1 transmit, 0 receive
  input  wire logic                            xact_odd_i,      // 1 odd bank, 0 even bank
  input  wire logic                            setup_rx_i,      // setup token received pulse
  input  wire logic                            se0_pin_i,       // async single-ended zero level
  output logic                                 packet_processing_halt_o, // halt token handling
  output logic                                 host_capability_on_o,     // host mode enable
  output logic                                 resume_o,        // resume signalling enable
  output logic                                 pingpong_pointer_clear_o, // ping-pong reset
  output logic                                 module_on_o      // module enable
);
  import usb_stat_pkg::*;

  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_s1_reg;
  logic rst_n;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // ************************************************************
  // single-ended zero synchroniser
  // ************************************************************
  logic se0_sync;
  sync2 u_se0_sync (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .d_i     (se0_pin_i),
    .q_o     (se0_sync)
  );

  // ************************************************************
  // decode
  // ************************************************************
  wire        hit_status  = (addr_i == LAST_STATUS_ADDR);
  wire        hit_control = (addr_i == USB_CONTROL_ADDR);
  wire        ctrl_wr     = wr_i && hit_control;

  // ************************************************************
  // last_transfer_status
  // ************************************************************
  logic [EP_W-1:0] last_endpoint_number_reg;
  logic            dir_reg;
  logic            pingpong_bank_indicator_reg;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      last_endpoint_number_reg    <= '0;
      dir_reg                     <= 1'b0;
      pingpong_bank_indicator_reg <= 1'b0;
    end else if (xact_done_i) begin
      last_endpoint_number_reg    <= xact_ep_i;
      dir_reg                     <= xact_tx_i;
      pingpong_bank_indicator_reg <= xact_odd_i;
    end
  end

  wire [DATA_W-1:0] status_view = {8'h00, last_endpoint_number_reg, dir_reg,
                                   pingpong_bank_indicator_reg, 2'b00};

  // ************************************************************
  // usb_control
  // ************************************************************
  logic [DATA_W-1:0] ctrl_reg;
  logic [DATA_W-1:0] ctrl_next;
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_wr) begin
      ctrl_next = wdata_i & CTRL_RW_MASK;
    end
    if (setup_rx_i) begin
      ctrl_next[HALT_BIT] = 1'b1;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CONTROL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  wire [DATA_W-1:0] ctrl_view = ctrl_reg | ({{(DATA_W-1){1'b0}}, se0_sync} << SE0_BIT);

  // ************************************************************
  // read port and outputs
  // ************************************************************
  wire [DATA_W-1:0] rd_mux = hit_status  ? status_view :
                             hit_control ? ctrl_view   : '0;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o                  <= '0;
      packet_processing_halt_o <= 1'b0;
      host_capability_on_o     <= 1'b0;
      resume_o                 <= 1'b0;
      pingpong_pointer_clear_o <= 1'b0;
      module_on_o              <= 1'b0;
    end else begin
      rdata_o                  <= rd_i ? rd_mux : '0;
      packet_processing_halt_o <= ctrl_next[HALT_BIT];
      host_capability_on_o     <= ctrl_next[HOST_BIT];
      resume_o                 <= ctrl_next[RESUME_BIT];
      pingpong_pointer_clear_o <= ctrl_next[PPCLR_BIT];
      module_on_o              <= ctrl_next[ON_BIT];
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_status_update;
    @(posedge core_clk_i) disable iff (!rst_n)
      xact_done_i |=> (last_endpoint_number_reg == $past(xact_ep_i)) && (dir_reg == $past(xact_tx_i))
                      && (pingpong_bank_indicator_reg == $past(xact_odd_i));
  endproperty
  a_status_update: assert property (p_status_update) else $error("status fields not updated");

  property p_status_hold;
    @(posedge core_clk_i) disable iff (!rst_n)
      !xact_done_i |=> $stable(status_view);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status changed without transaction");

  property p_ep_read;
    @(posedge core_clk_i) disable iff (!rst_n)
      (rd_i && hit_status) |=> (rdata_o[7:4] == $past(last_endpoint_number_reg));
  endproperty
  a_ep_read: assert property (p_ep_read) else $error("endpoint read wrong");

  property p_dir_read;
    @(posedge core_clk_i) disable iff (!rst_n)
      (xact_done_i ##1 !xact_done_i ##1 (rd_i && hit_status && !xact_done_i))
        |=> rdata_o[DIR_BIT] == $past(xact_tx_i, 3);
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction read wrong");

  property p_bank_read;
    @(posedge core_clk_i) disable iff (!rst_n)
      (xact_done_i ##1 !xact_done_i ##1 (rd_i && hit_status && !xact_done_i))
        |=> rdata_o[BANK_BIT] == $past(xact_odd_i, 3);
  endproperty
  a_bank_read: assert property (p_bank_read) else $error("bank read wrong");

  property p_unimpl_zero;
    @(posedge core_clk_i) disable iff (!rst_n)
      (rd_i && hit_status) |=> (rdata_o[15:8] == 8'h00) && (rdata_o[1:0] == 2'b00);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented status bits nonzero");

  property p_se0_live;
    @(posedge core_clk_i) disable iff (!rst_n)
      (rd_i && hit_control) |=> rdata_o[SE0_BIT] == $past(se0_sync);
  endproperty
  a_se0_live: assert property (p_se0_live) else $error("live bus flag wrong");

  property p_setup_halt;
    @(posedge core_clk_i) disable iff (!rst_n)
      setup_rx_i |=> ctrl_reg[HALT_BIT] && packet_processing_halt_o;
  endproperty
  a_setup_halt: assert property (p_setup_halt) else $error("setup did not halt");

  property p_status_ro;
    @(posedge core_clk_i) disable iff (!rst_n)
      (wr_i && hit_status && !xact_done_i) |=> $stable(status_view);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status changed by software write");

  property p_status_reset;
    @(posedge core_clk_i)
      $rose(rst_n) |-> (status_view == STATUS_RESET);
  endproperty
  a_status_reset: assert property (p_status_reset) else $error("status not cleared by reset");

  property p_halt_hold;
    @(posedge core_clk_i) disable iff (!rst_n)
      (ctrl_reg[HALT_BIT] && !ctrl_wr) |=> ctrl_reg[HALT_BIT];
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt dropped without software clear");

  property p_halt_clear;
    @(posedge core_clk_i) disable iff (!rst_n)
      (ctrl_wr && !wdata_i[HALT_BIT] && !setup_rx_i) |=> !ctrl_reg[HALT_BIT] && !packet_processing_halt_o;
  endproperty
  a_halt_clear: assert property (p_halt_clear) else $error("halt not cleared by software");

  property p_se0_rise;
    @(posedge core_clk_i) disable iff (!rst_n)
      ($rose(se0_pin_i) ##1 se0_pin_i) |=> ctrl_view[SE0_BIT];
  endproperty
  a_se0_rise: assert property (p_se0_rise) else $error("live bus flag late");

endmodule // usb_last_transfer_status

// [rtl/usb_stat_pkg.sv]
// Purpose: constants for the usb last-transfer status and control block
// Assumes: 16-bit registers reached over a plain strobe port
// Notes:   offsets are word indices of the local register port
package usb_stat_pkg;
  localparam int          ADDR_W            = 4;
  localparam int          DATA_W            = 16;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [3:0]  LAST_STATUS_ADDR  = 4'h0;
  localparam logic [3:0]  USB_CONTROL_ADDR  = 4'h1;
  // ************************************************************
  // last_transfer_status fields
  // ************************************************************
  localparam int          EP_LSB            = 4;
  localparam int          EP_W              = 4;
  localparam int          DIR_BIT           = 3;
  localparam int          BANK_BIT          = 2;
  // ************************************************************
  // usb_control fields
  // ************************************************************
  localparam int          SE0_BIT           = 6;
  localparam int          HALT_BIT          = 5;
  localparam int          HOST_BIT          = 3;
  localparam int          RESUME_BIT        = 2;
  localparam int          PPCLR_BIT         = 1;
  localparam int          ON_BIT            = 0;
  localparam logic [15:0] CTRL_RW_MASK      = 16'h002F;
  localparam logic [15:0] STATUS_RESET      = 16'h0000;
  localparam logic [15:0] CONTROL_RESET     = 16'h0000;
endpackage : usb_stat_pkg

// [tb/tb_usb_last_transfer_status.sv]
// Purpose: self-checking bench for the last-transfer status block
// Assumes: index 0 status, 1 control, read data in the cycle after the strobe
// Notes:   all waits are fixed counts
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_usb_last_transfer_status;
  import usb_stat_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        resetn_i   = 1'b0;
  logic [3:0]  addr_i     = 4'h0;
  logic [15:0] wdata_i    = 16'h0000;
  logic        wr_i       = 1'b0;
  logic        rd_i       = 1'b0;
  logic [15:0] rdata_o;
  logic        done, tx, odd, setup, se0;
  logic [3:0]  ep;
  wire  [4:0]  ctl_o;
  int          err_total       = 0;
  int          samples_checked = 0;
  always #10 core_clk_i = ~core_clk_i;
  usb_far_side_model u_far (.clk_i(core_clk_i), .done_o(done), .ep_o(ep), .tx_o(tx),
    .odd_o(odd), .setup_o(setup), .se0_o(se0));
  usb_last_transfer_status DUT (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .xact_done_i(done),
    .xact_ep_i(ep), .xact_tx_i(tx), .xact_odd_i(odd), .setup_rx_i(setup), .se0_pin_i(se0),
    .packet_processing_halt_o(ctl_o[4]), .host_capability_on_o(ctl_o[3]),
    .resume_o(ctl_o[2]), .pingpong_pointer_clear_o(ctl_o[1]), .module_on_o(ctl_o[0]));
  // ************************************************************
  // bus tasks
  // ************************************************************
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic reg_check(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk_i);
    {rd_i, addr_i} <= {1'b1, a};
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 `CHK(rdata_o, exp)
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_reset();
    reg_check(LAST_STATUS_ADDR, STATUS_RESET);
    reg_check(USB_CONTROL_ADDR, CONTROL_RESET);
    `CHK(ctl_o, 5'h00)
    $display("test_reset done");
  endtask
  task automatic test_endpoints();
    for (int i = 0; i < 16; i++) begin
      u_far.xact(4'(i), i[0], i[1]);
      u_far.xact(4'(15 - i), ~i[0], ~i[1]);
      u_far.xact(4'(i), i[0], i[1]);
      reg_check(LAST_STATUS_ADDR, {8'h00, 4'(i), i[0], i[1], 2'b00});
    end
    $display("test_endpoints done");
  endtask
  task automatic test_read_only();
    u_far.xact(4'hA, 1'b1, 1'b0);
    reg_write(LAST_STATUS_ADDR, 16'hFFFF);
    reg_check(LAST_STATUS_ADDR, 16'h00A8);
    reg_write(4'h7, 16'hFFFF);
    reg_check(4'h7, 16'h0000);
    $display("test_read_only done");
  endtask
  task automatic test_control();
    reg_write(USB_CONTROL_ADDR, 16'hFFFF);
    reg_check(USB_CONTROL_ADDR, 16'h002F);
    `CHK(ctl_o, 5'h1F)
    reg_write(USB_CONTROL_ADDR, 16'h0000);
    u_far.line(1'b1);
    repeat (4) @(posedge core_clk_i);
    reg_check(USB_CONTROL_ADDR, 16'h0040);
    u_far.line(1'b0);
    repeat (4) @(posedge core_clk_i);
    reg_check(USB_CONTROL_ADDR, 16'h0000);
    u_far.setup_token();
    reg_check(USB_CONTROL_ADDR, 16'h0020);
    `CHK(ctl_o, 5'h10)
    fork
      u_far.setup_token();
      reg_write(USB_CONTROL_ADDR, 16'h0000);
    join
    reg_check(USB_CONTROL_ADDR, 16'h0020);
    reg_write(USB_CONTROL_ADDR, 16'h0000);
    reg_check(USB_CONTROL_ADDR, 16'h0000);
    $display("test_control done");
  endtask
  task automatic test_midrun_reset();
    u_far.xact(4'h5, 1'b1, 1'b1);
    reg_write(USB_CONTROL_ADDR, 16'h0021);
    reg_check(LAST_STATUS_ADDR, 16'h005C);
    @(posedge core_clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    reg_check(LAST_STATUS_ADDR, STATUS_RESET);
    reg_check(USB_CONTROL_ADDR, CONTROL_RESET);
    `CHK(ctl_o, 5'h00)
    $display("test_midrun_reset done");
  endtask
  initial begin
    repeat (12) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    test_reset();
    test_endpoints();
    test_read_only();
    test_control();
    test_midrun_reset();
    tally_and_finish();
  end
  initial begin
    #1000000;
    err_total++;
    tally_and_finish();
  end
endmodule // tb_usb_last_transfer_status

// [tb/usb_far_side_model.sv]
// Purpose: behavioural engine side that raises transaction, token and line events
// Assumes: events start right after a rising clock edge
// Notes:   fields show zero before the first done pulse and inverted values after each one
`timescale 1ns/1ns
module usb_far_side_model (
  input  wire logic       clk_i,   // core clock
  output logic            done_o,  // transaction complete pulse
  output logic [3:0]      ep_o,    // endpoint number
  output logic            tx_o,    // direction
  output logic            odd_o,   // bank
  output logic            setup_o, // setup token pulse
  output logic            se0_o    // line level
);
  initial begin
    {done_o, ep_o, tx_o, odd_o, setup_o, se0_o} = 9'h000;
  end
  // bank flag is only meant for endpoints with both banks
  task automatic xact(input logic [3:0] ep, input logic tx, input logic odd);
    @(posedge clk_i);
    {done_o, ep_o, tx_o, odd_o} <= {1'b1, ep, tx, odd};
    @(posedge clk_i);
    {done_o, ep_o, tx_o, odd_o} <= {1'b0, ~ep, ~tx, ~odd};
  endtask
  task automatic setup_token();
    @(posedge clk_i);
    setup_o <= 1'b1;
    @(posedge clk_i);
    setup_o <= 1'b0;
  endtask
  task automatic line(input logic v);
    @(posedge clk_i);
    se0_o <= v;
  endtask
endmodule // usb_far_side_model
